/* File: include/lbe_pkg.sv */
// package for the ladder bit logic evaluator: opcodes, forms, sizes
package lbe_pkg;

	localparam int LBE_WORD_W    = 16;
	localparam int LBE_BITN_W    = 4;
	localparam int LBE_SLOT_W    = 8;
	localparam int LBE_SLOTS     = 256;
	localparam int LBE_STK_DEPTH = 8;
	localparam int LBE_DEPTH_W   = 4;
	localparam int LBE_OPC_W     = 10;

	localparam logic [LBE_DEPTH_W-1:0] LBE_DEPTH_RST = 4'h0;
	localparam logic [LBE_DEPTH_W-1:0] LBE_DEPTH_MAX = 4'h8;
	localparam logic [LBE_DEPTH_W-1:0] LBE_DEPTH_ONE = 4'h1;
	localparam logic                   LBE_COND_RST  = 1'b0;

	// opcode values; the low ones are an arbitrary internal encoding
	localparam logic [LBE_OPC_W-1:0] LBE_OPC_NOP      = 10'h000;
	localparam logic [LBE_OPC_W-1:0] LBE_OPC_LOAD     = 10'h001;
	localparam logic [LBE_OPC_W-1:0] LBE_OPC_LOAD_INV = 10'h002;
	localparam logic [LBE_OPC_W-1:0] LBE_OPC_AND      = 10'h003;
	localparam logic [LBE_OPC_W-1:0] LBE_OPC_AND_INV  = 10'h004;
	localparam logic [LBE_OPC_W-1:0] LBE_OPC_OR       = 10'h005;
	localparam logic [LBE_OPC_W-1:0] LBE_OPC_OR_INV   = 10'h006;
	localparam logic [LBE_OPC_W-1:0] LBE_OPC_SER_MRG  = 10'h007;
	localparam logic [LBE_OPC_W-1:0] LBE_OPC_PAR_MRG  = 10'h008;
	localparam logic [LBE_OPC_W-1:0] LBE_OPC_RUNG_END = 10'h3ff;
	localparam logic [LBE_OPC_W-1:0] LBE_OPC_WBIT     = 10'h15e;
	localparam logic [LBE_OPC_W-1:0] LBE_OPC_WBIT_INV = 10'h15f;
	localparam logic [LBE_OPC_W-1:0] LBE_OPC_NOT      = 10'h208;
	localparam logic [LBE_OPC_W-1:0] LBE_OPC_UP       = 10'h209;
	localparam logic [LBE_OPC_W-1:0] LBE_OPC_DOWN     = 10'h20a;

	typedef enum logic [1:0] {
		LBE_FORM_START    = 2'h0,
		LBE_FORM_SERIES   = 2'h1,
		LBE_FORM_PARALLEL = 2'h2
	} lbe_form_t;

	typedef struct packed {
		logic [LBE_OPC_W-1:0]  opcode;
		lbe_form_t             form;
		logic                  bit_val;
		logic [LBE_WORD_W-1:0] src_word;
		logic [LBE_BITN_W-1:0] bit_num;
		logic [LBE_SLOT_W-1:0] slot;
	} lbe_instr_t;

endpackage

/* File: rtl/lbe_evaluator.sv */
// ladder bit logic evaluator: execution condition, block stack, edge memory
`timescale 1ns/1ps
module lbe_evaluator
	import lbe_pkg::*;
(
	input  wire logic                   clk_sys,
	input  wire logic                   sys_rst,
	input  wire logic                   instr_valid,
	input  wire lbe_instr_t             instr,
	output logic                        cond_r,
	output logic                        done_r,
	output logic                        block_live_r,
	output logic [LBE_DEPTH_W-1:0]      depth_r,
	output logic                        overflow_r,
	output logic                        underflow_r
);

	logic                   cond_nxt;
	logic [LBE_DEPTH_W-1:0] depth_nxt;
	logic                   live_nxt;
	logic                   stk_r [LBE_STK_DEPTH];
	logic [LBE_SLOTS-1:0]   prev_r;

	wire is_wbt   = instr.opcode == LBE_OPC_WBIT;
	wire is_wbti  = instr.opcode == LBE_OPC_WBIT_INV;
	wire f_start  = instr.form == LBE_FORM_START;
	wire f_series = instr.form == LBE_FORM_SERIES;
	wire f_par    = instr.form == LBE_FORM_PARALLEL;

	// word tests reuse the plain forms; only the operand source differs
	wire use_word = is_wbt | is_wbti;
	wire word_bit = instr.src_word[instr.bit_num];
	wire opnd     = use_word ? word_bit : instr.bit_val;

	wire d_load = instr.opcode == LBE_OPC_LOAD     | (is_wbt & f_start);
	wire d_ldn  = instr.opcode == LBE_OPC_LOAD_INV | (is_wbti & f_start);
	wire d_and  = instr.opcode == LBE_OPC_AND      | (is_wbt & f_series);
	wire d_andn = instr.opcode == LBE_OPC_AND_INV  | (is_wbti & f_series);
	wire d_or   = instr.opcode == LBE_OPC_OR       | (is_wbt & f_par);
	wire d_orn  = instr.opcode == LBE_OPC_OR_INV   | (is_wbti & f_par);
	wire d_smrg = instr.opcode == LBE_OPC_SER_MRG;
	wire d_pmrg = instr.opcode == LBE_OPC_PAR_MRG;
	wire d_not  = instr.opcode == LBE_OPC_NOT;
	wire d_up   = instr.opcode == LBE_OPC_UP;
	wire d_down = instr.opcode == LBE_OPC_DOWN;
	wire d_end  = instr.opcode == LBE_OPC_RUNG_END;

	wire go_load = instr_valid & d_load;
	wire go_ldn  = instr_valid & d_ldn;
	wire go_and  = instr_valid & d_and;
	wire go_andn = instr_valid & d_andn;
	wire go_or   = instr_valid & d_or;
	wire go_orn  = instr_valid & d_orn;
	wire go_smrg = instr_valid & d_smrg;
	wire go_pmrg = instr_valid & d_pmrg;
	wire go_not  = instr_valid & d_not;
	wire go_up   = instr_valid & d_up;
	wire go_down = instr_valid & d_down;
	wire go_end  = instr_valid & d_end;

	wire go_start = go_load | go_ldn;
	wire go_merge = go_smrg | go_pmrg;

	// stack: a full stack drops the push but the new block still loads
	wire stk_full  = depth_r == LBE_DEPTH_MAX;
	wire stk_empty = depth_r == LBE_DEPTH_RST;
	wire do_push   = go_start & block_live_r & ~stk_full;
	wire ovf_ev    = go_start & block_live_r & stk_full;
	wire unf_ev    = go_merge & stk_empty;
	wire do_pop    = go_merge & ~stk_empty;

	wire [LBE_DEPTH_W-1:0] top_idx = depth_r - LBE_DEPTH_ONE;
	wire                   stk_top = stk_r[top_idx[2:0]];
	wire                   prev_sel = prev_r[instr.slot];

	wire c_load = opnd;
	wire c_ldn  = ~opnd;
	wire c_and  = cond_r & opnd;
	wire c_andn = cond_r & ~opnd;
	wire c_or   = cond_r | opnd;
	wire c_orn  = cond_r | ~opnd;
	wire c_smrg = stk_top & cond_r;
	wire c_pmrg = stk_top | cond_r;
	wire c_not  = ~cond_r;
	wire c_up   = cond_r & ~prev_sel;
	wire c_down = ~cond_r & prev_sel;

	assign cond_nxt =
		go_load ? c_load :
		go_ldn  ? c_ldn  :
		go_and  ? c_and  :
		go_andn ? c_andn :
		go_or   ? c_or   :
		go_orn  ? c_orn  :
		do_pop & go_smrg ? c_smrg :
		do_pop & go_pmrg ? c_pmrg :
		go_not  ? c_not  :
		go_up   ? c_up   :
		go_down ? c_down :
		go_end  ? LBE_COND_RST : cond_r;

	assign depth_nxt =
		go_end  ? LBE_DEPTH_RST :
		do_push ? depth_r + LBE_DEPTH_ONE :
		do_pop  ? depth_r - LBE_DEPTH_ONE : depth_r;

	assign live_nxt = go_end ? 1'b0 : (go_start ? 1'b1 : block_live_r);

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			cond_r       <= LBE_COND_RST;
			done_r       <= 1'b0;
			block_live_r <= 1'b0;
			depth_r      <= LBE_DEPTH_RST;
			overflow_r   <= 1'b0;
			underflow_r  <= 1'b0;
		end
		else
		begin
			cond_r       <= cond_nxt;
			done_r       <= instr_valid;
			block_live_r <= live_nxt;
			depth_r      <= depth_nxt;
			overflow_r   <= ovf_ev;
			underflow_r  <= unf_ev;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < LBE_STK_DEPTH; gi++)
		begin : g_stk
			wire wr = do_push & (depth_r[2:0] == 3'(gi));
			always_ff @(posedge clk_sys)
			begin
				if (sys_rst)
					stk_r[gi] <= 1'b0;
				else if (wr)
					stk_r[gi] <= cond_r;
			end
		end
		// one remembered input per edge instance, kept across scans
		for (gi = 0; gi < LBE_SLOTS; gi++)
		begin : g_edge
			wire wr = (go_up | go_down) & (instr.slot == LBE_SLOT_W'(gi));
			always_ff @(posedge clk_sys)
			begin
				if (sys_rst)
					prev_r[gi] <= 1'b0;
				else if (wr)
					prev_r[gi] <= cond_r;
			end
		end
	endgenerate

	AST_LOAD: assert property (@(posedge clk_sys) disable iff (sys_rst)
		go_load |=> cond_r == $past(opnd) && block_live_r)
		else $error("load did not copy operand");

	AST_LOAD_INV: assert property (@(posedge clk_sys) disable iff (sys_rst)
		go_ldn |=> cond_r == !$past(opnd))
		else $error("inverted load wrong");

	AST_AND: assert property (@(posedge clk_sys) disable iff (sys_rst)
		go_and |=> cond_r == ($past(cond_r) && $past(opnd)))
		else $error("series and wrong");

	AST_AND_INV: assert property (@(posedge clk_sys) disable iff (sys_rst)
		go_andn |=> cond_r == ($past(cond_r) && !$past(opnd)))
		else $error("series and-inverted wrong");

	AST_OR: assert property (@(posedge clk_sys) disable iff (sys_rst)
		go_or |=> cond_r == ($past(cond_r) || $past(opnd)))
		else $error("parallel or wrong");

	AST_OR_INV: assert property (@(posedge clk_sys) disable iff (sys_rst)
		go_orn |=> cond_r == ($past(cond_r) || !$past(opnd)))
		else $error("parallel or-inverted wrong");

	AST_SER_MERGE: assert property (@(posedge clk_sys) disable iff (sys_rst)
		go_smrg && !stk_empty |=> cond_r == ($past(stk_top) && $past(cond_r))
			&& depth_r == $past(depth_r) - LBE_DEPTH_ONE)
		else $error("series merge wrong");

	AST_PAR_MERGE: assert property (@(posedge clk_sys) disable iff (sys_rst)
		go_pmrg && !stk_empty |=> cond_r == ($past(stk_top) || $past(cond_r)))
		else $error("parallel merge wrong");

	AST_NOT: assert property (@(posedge clk_sys) disable iff (sys_rst)
		go_not |=> cond_r != $past(cond_r))
		else $error("invert did not flip condition");

	AST_UP: assert property (@(posedge clk_sys) disable iff (sys_rst)
		go_up ##1 (instr_valid && d_up && instr.slot == $past(instr.slot)
			&& cond_r == $past(cond_r)) |=> !cond_r)
		else $error("rising pulse lasted more than one pass");

	AST_DOWN: assert property (@(posedge clk_sys) disable iff (sys_rst)
		go_down |=> cond_r == (!$past(cond_r) && $past(prev_sel))
			&& prev_r[$past(instr.slot)] == $past(cond_r))
		else $error("falling pulse wrong");

	AST_WBIT: assert property (@(posedge clk_sys) disable iff (sys_rst)
		instr_valid && is_wbt && f_start |=> cond_r == $past(word_bit))
		else $error("word bit test wrong");

	AST_WBIT_INV: assert property (@(posedge clk_sys) disable iff (sys_rst)
		instr_valid && is_wbti && f_series |=> cond_r == ($past(cond_r) && !$past(word_bit)))
		else $error("inverted word bit test wrong");

	AST_PUSH: assert property (@(posedge clk_sys) disable iff (sys_rst)
		do_push |=> depth_r == $past(depth_r) + LBE_DEPTH_ONE
			&& stk_r[$past(depth_r[2:0])] == $past(cond_r))
		else $error("pending block not saved");

	AST_LOAD_INV_LIVE: assert property (@(posedge clk_sys) disable iff (sys_rst)
		go_ldn |=> block_live_r)
		else $error("inverted load did not open a block");

	AST_NO_PUSH_FIRST: assert property (@(posedge clk_sys) disable iff (sys_rst)
		go_start && !block_live_r
			|=> depth_r == $past(depth_r))
		else $error("first block pushed a result");

	AST_OVERFLOW: assert property (@(posedge clk_sys) disable iff (sys_rst)
		go_start && block_live_r && stk_full |=> overflow_r
			&& depth_r == LBE_DEPTH_MAX)
		else $error("full stack not flagged");

	AST_UNDERFLOW: assert property (@(posedge clk_sys) disable iff (sys_rst)
		go_merge && stk_empty |=> underflow_r && depth_r == LBE_DEPTH_RST
			&& cond_r == $past(cond_r))
		else $error("merge on empty stack changed state");

	AST_PAR_DEPTH: assert property (@(posedge clk_sys) disable iff (sys_rst)
		go_pmrg && !stk_empty |=> depth_r == $past(depth_r) - LBE_DEPTH_ONE)
		else $error("parallel merge did not pop");

	AST_UP_VALUE: assert property (@(posedge clk_sys) disable iff (sys_rst)
		go_up |=> cond_r == ($past(cond_r) && !$past(prev_sel))
			&& prev_r[$past(instr.slot)] == $past(cond_r))
		else $error("rising pulse wrong");

	AST_WBIT_AND: assert property (@(posedge clk_sys) disable iff (sys_rst)
		instr_valid && is_wbt && f_series |=> cond_r == ($past(cond_r) && $past(word_bit)))
		else $error("series word bit test wrong");

	AST_WBIT_OR: assert property (@(posedge clk_sys) disable iff (sys_rst)
		instr_valid && is_wbt && f_par |=> cond_r == ($past(cond_r) || $past(word_bit)))
		else $error("parallel word bit test wrong");

	AST_WBIT_INV_START: assert property (@(posedge clk_sys) disable iff (sys_rst)
		instr_valid && is_wbti && f_start |=> cond_r == !$past(word_bit))
		else $error("inverted word bit start wrong");

	AST_WBIT_INV_OR: assert property (@(posedge clk_sys) disable iff (sys_rst)
		instr_valid && is_wbti && f_par
			|=> cond_r == ($past(cond_r) || !$past(word_bit)))
		else $error("inverted parallel word bit test wrong");

	AST_DONE: assert property (@(posedge clk_sys) disable iff (sys_rst)
		instr_valid |=> done_r)
		else $error("done missing after instruction");

	AST_DONE_PULSE: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!instr_valid |=> !done_r)
		else $error("done without instruction");

	AST_IDLE_HOLD: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!instr_valid |=> cond_r == $past(cond_r)
			&& depth_r == $past(depth_r) && block_live_r == $past(block_live_r))
		else $error("state moved without instruction");

	AST_NO_FLAGS: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!instr_valid |=> !overflow_r && !underflow_r)
		else $error("stack flag without instruction");

	AST_RUNG_CLEAR: assert property (@(posedge clk_sys) disable iff (sys_rst)
		go_end |=> !cond_r && !block_live_r && depth_r == LBE_DEPTH_RST)
		else $error("rung end did not clear");

	AST_MERGE_LIVE: assert property (@(posedge clk_sys) disable iff (sys_rst)
		go_merge |=> block_live_r == $past(block_live_r))
		else $error("merge changed block state");

endmodule

/* File: test/lbe_seq_model.sv */
// sequencer and bit memory model feeding the evaluator
`timescale 1ns/1ps
module lbe_seq_model
	import lbe_pkg::*;
(
	input  wire logic clk_sys,
	output logic       instr_valid,
	output lbe_instr_t instr
);
	logic [LBE_WORD_W-1:0] mem [4];
	initial
	begin
		instr_valid = 1'b0;
		instr       = '0;
		mem         = '{16'h8021, 16'h4000, 16'h0000, 16'hffff};
	end
	// one instruction per falling edge, back to back
	task automatic op(input logic [LBE_OPC_W-1:0] opc, input logic b = 1'b0,
		input lbe_form_t f = LBE_FORM_START, input logic [1:0] w = 2'h0,
		input logic [LBE_BITN_W-1:0] n = 4'h0, input logic [LBE_SLOT_W-1:0] s = 8'h00);
		@(negedge clk_sys);
		instr_valid = 1'b1;
		instr       = '{opc, f, b, mem[w], n, s};
	endtask
	// released bus shows the inverse, not a stale copy
	task automatic idle();
		@(negedge clk_sys);
		instr_valid = 1'b0;
		instr       = ~instr;
	endtask
endmodule

/* File: test/tb_ladder_bit_logic_evaluator.sv */
// self-checking bench for the ladder bit logic evaluator
`timescale 1ns/1ps
module tb_ladder_bit_logic_evaluator;
	import lbe_pkg::*;
	logic                   clk_sys;
	logic                   sys_rst;
	logic                   instr_valid;
	lbe_instr_t             instr;
	logic                   cond_r;
	logic                   done_r;
	logic                   live;
	logic                   ovf;
	logic                   unf;
	logic [LBE_DEPTH_W-1:0] depth_r;
	int                     n_errors;
	int                     num_checks;
	logic [3:0]             nb [4] = '{4'h0, 4'h5, 4'he, 4'hf};
	lbe_seq_model u_seq (.clk_sys(clk_sys), .instr_valid(instr_valid), .instr(instr));
	lbe_evaluator DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .instr_valid(instr_valid),
		.instr(instr), .cond_r(cond_r), .done_r(done_r), .block_live_r(live),
		.depth_r(depth_r), .overflow_r(ovf), .underflow_r(unf));
	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic t_plain();
		logic c0;
		logic e;
		for (int s = 1; s <= 2; s++)
			for (int k = 0; k < 16; k++)
			begin
				c0 = k[0] ^ (s == 2);
				e  = (k[3:2] == 2'h0) ? c0 & k[1] : (k[3:2] == 2'h1) ? c0 & ~k[1] :
					(k[3:2] == 2'h2) ? c0 | k[1] : c0 | ~k[1];
				u_seq.op(LBE_OPC_RUNG_END);
				u_seq.op(10'(s), k[0]);
				u_seq.op(LBE_OPC_AND + {8'h00, k[3:2]}, k[1]);
				u_seq.idle();
				check("plain cond", {3'h0, cond_r}, {3'h0, e});
				check("done", {3'h0, done_r & live}, 4'h1);
			end
	endtask
	task automatic t_bit();
		logic v;
		logic v2;
		logic e;
		for (int k = 0; k < 16; k++)
		begin
			v  = 16'h8021 >> nb[k[1:0]];
			v2 = 16'h4000 >> nb[k[1:0]];
			e  = k[3] ? (v ^ k[2]) | (v2 ^ k[2]) : (v ^ k[2]) & (v2 ^ k[2]);
			u_seq.op(LBE_OPC_RUNG_END);
			u_seq.op(k[2] ? LBE_OPC_WBIT_INV : LBE_OPC_WBIT, 1'b0, LBE_FORM_START,
				2'h0, nb[k[1:0]]);
			u_seq.op(k[2] ? LBE_OPC_WBIT_INV : LBE_OPC_WBIT, ~e,
				k[3] ? LBE_FORM_PARALLEL : LBE_FORM_SERIES, 2'h1, nb[k[1:0]]);
			u_seq.idle();
			check("bit test cond", {3'h0, cond_r}, {3'h0, e});
		end
	endtask
	task automatic t_stack();
		u_seq.op(LBE_OPC_RUNG_END);
		u_seq.op(LBE_OPC_LOAD, 1'b1);
		u_seq.op(LBE_OPC_LOAD, 1'b0);
		u_seq.idle();
		check("depth push", depth_r, 4'h1);
		u_seq.op(LBE_OPC_PAR_MRG);
		u_seq.idle();
		check("par merge", {depth_r[2:0], cond_r}, 4'h1);
		u_seq.op(LBE_OPC_RUNG_END);
		u_seq.op(LBE_OPC_LOAD, 1'b0);
		u_seq.op(LBE_OPC_LOAD, 1'b1);
		u_seq.op(LBE_OPC_SER_MRG);
		u_seq.op(LBE_OPC_SER_MRG);
		u_seq.idle();
		check("ser merge, underflow", {unf, depth_r[2:0]}, 4'h8);
		check("ser merge cond", {3'h0, cond_r}, 4'h0);
		u_seq.op(LBE_OPC_RUNG_END);
		repeat (9) u_seq.op(LBE_OPC_LOAD, 1'b1);
		u_seq.op(LBE_OPC_LOAD, 1'b0);
		u_seq.idle();
		check("overflow depth", {3'h0, ovf}, 4'h1);
		check("full depth", depth_r, LBE_DEPTH_MAX);
	endtask
	task automatic t_edge();
		logic prev;
		logic in;
		prev = 1'b0;
		for (int i = 0; i < 5; i++)
		begin
			in = 5'b00110 >> i;
			u_seq.op(LBE_OPC_RUNG_END);
			u_seq.op(LBE_OPC_LOAD, in);
			u_seq.op(LBE_OPC_UP, 1'b0, LBE_FORM_START, 2'h0, 4'h0, 8'h03);
			u_seq.idle();
			check("rise pulse", {3'h0, cond_r}, {3'h0, in & ~prev});
			u_seq.op(LBE_OPC_RUNG_END);
			u_seq.op(LBE_OPC_LOAD, in);
			u_seq.op(LBE_OPC_DOWN, 1'b0, LBE_FORM_START, 2'h0, 4'h0, 8'h04);
			u_seq.op(LBE_OPC_NOT);
			u_seq.idle();
			check("fall pulse then invert", {3'h0, cond_r}, {3'h0, ~(~in & prev)});
			prev = in;
		end
	endtask
	initial
	begin
		#(25 * 6000);
		n_errors++;
		test_done();
	end
	initial
	begin
		n_errors   = 0;
		num_checks = 0;
		sys_rst    = 1'b1;
		repeat (5) @(negedge clk_sys);
		sys_rst = 1'b0;
		check("reset state", {cond_r, live, depth_r[1:0]}, 4'h0);
		t_plain();
		t_bit();
		t_stack();
		t_edge();
		test_done();
	end
endmodule
